// *** satoc_cfg.svh ***
`ifndef SATOC_CFG_SVH
`define SATOC_CFG_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define SATOC_OFS_OTRIM_HI   8'h84
`define SATOC_OFS_OTRIM_LO   8'h85
`define SATOC_OFS_GAIN_TRIM  8'h86
`define SATOC_OFS_OC_CFG     8'h87
`define SATOC_OFS_HI_LIMIT   8'h88
`define SATOC_OFS_LO_LIMIT   8'h89

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define SATOC_RST_OTRIM_HI   16'h0000
`define SATOC_RST_OTRIM_LO   8'h00
`define SATOC_RST_GAIN_TRIM  16'h0000
`define SATOC_RST_OC_CFG     16'h0000
`define SATOC_RST_HI_LIMIT   16'h7FFF
`define SATOC_RST_LO_LIMIT   16'h8000

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SATOC_BIT_OC_EN      15
`define SATOC_BIT_OC_POL     14
`define SATOC_BIT_OC_RSVD    13
`define SATOC_DGL_MSB        12
`define SATOC_DGL_LSB        8
`define SATOC_OTRIM_LO_MSB   15
`define SATOC_OTRIM_LO_LSB   8

// ----------------------------------------------------------------------
// Fast filter and scaling
// ----------------------------------------------------------------------
`define SATOC_FAST_OSR_LOG2  6
`define SATOC_FAST_WIDTH     20
`define SATOC_FAST_SHIFT     3
`define SATOC_GAIN_UNITY     18'h10000

`endif

// *** satoc_pkg.sv ***
package satoc_pkg;

    // Register port request, one access per cycle
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } satoc_reg_req_t;

    // Conversion sample with its strobe
    typedef struct packed {
        logic        valid;
        logic [23:0] data;
    } satoc_sample_t;

    // Channel gain setting codes
    typedef enum logic [1:0] {
        SATOC_GAIN_4  = 2'b00,
        SATOC_GAIN_8  = 2'b01,
        SATOC_GAIN_16 = 2'b10,
        SATOC_GAIN_32 = 2'b11
    } satoc_gain_t;

endpackage : satoc_pkg

// *** satoc_sinc3.sv ***
`timescale 1ns/100ps
`default_nettype none

module satoc_sinc3 #(
    parameter int OSR_LOG2 = 6,
    parameter int WIDTH    = 20
) (
    input  wire logic              core_clk,
    input  wire logic              sys_rst,
    input  wire logic              clear,
    input  wire logic              bit_in,
    output logic                   out_valid,
    output logic signed [WIDTH-1:0] out_data
);

    // ------------------------------------------------------------------
    // Integrators, decimator and differentiators
    // ------------------------------------------------------------------
    logic signed [WIDTH-1:0] int1_q, int2_q, int3_q;
    logic signed [WIDTH-1:0] int1_d, int2_d, int3_d;
    logic signed [WIDTH-1:0] dly1_q, dly2_q, dly3_q;
    logic signed [WIDTH-1:0] dly1_d, dly2_d, dly3_d;
    logic signed [WIDTH-1:0] out_d;
    logic [OSR_LOG2-1:0]     dec_q, dec_d;
    logic                    vld_d;
    logic signed [WIDTH-1:0] step;
    logic signed [WIDTH-1:0] diff1, diff2, diff3;

    always_comb begin
        step   = bit_in ? WIDTH'(1) : -WIDTH'(1);
        int1_d = int1_q + step;
        int2_d = int2_q + int1_q;
        int3_d = int3_q + int2_q;
        dec_d  = dec_q + OSR_LOG2'(1);
        diff1  = int3_q - dly1_q;
        diff2  = diff1 - dly2_q;
        diff3  = diff2 - dly3_q;
        dly1_d = dly1_q;
        dly2_d = dly2_q;
        dly3_d = dly3_q;
        out_d  = out_data;
        vld_d  = 1'b0;
        if (dec_q == '1) begin
            dly1_d = int3_q;
            dly2_d = diff1;
            dly3_d = diff2;
            out_d  = diff3;
            vld_d  = 1'b1;
        end
        if (clear) begin
            int1_d = '0;
            int2_d = '0;
            int3_d = '0;
            dly1_d = '0;
            dly2_d = '0;
            dly3_d = '0;
            dec_d  = '0;
            out_d  = '0;
            vld_d  = 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            int1_q    <= '0;
            int2_q    <= '0;
            int3_q    <= '0;
            dly1_q    <= '0;
            dly2_q    <= '0;
            dly3_q    <= '0;
            dec_q     <= '0;
            out_data  <= '0;
            out_valid <= 1'b0;
        end else begin
            int1_q    <= int1_d;
            int2_q    <= int2_d;
            int3_q    <= int3_d;
            dly1_q    <= dly1_d;
            dly2_q    <= dly2_d;
            dly3_q    <= dly3_d;
            dec_q     <= dec_d;
            out_data  <= out_d;
            out_valid <= vld_d;
        end
    end

endmodule : satoc_sinc3

`default_nettype wire

// *** satoc_top.sv ***
// Summary of operation
// - Offset trim bits 23:8 held in their own register, LSB as conversion LSB.
// - Offset trim bits 7:0 in bits 15:8 of next register; 7:0 read zero.
// - Gain trim multiplies data by one plus trim over 65536.
// - Enable bit 15 turns fast filter and comparator on together; resets off.
// - Fast filter ignores conversion start and stop; only enable bit and channel A enable govern.
// - Polarity bit 14: zero drives low on fault; one drives high, or releases the pin in open-drain format.
// - Fault is the OR of the high and low limit flags.
// - Shared pin carries fault only when selected; format sets drive style.
// - Bits 12:8 choose how many filter outputs must exceed before tripping.
// - Deglitch codes map through a table: 1..10, wider steps, up to 128.
// - Fast filter is third-order sinc with ratio fixed at 64.
// - Counter restarts when a sample falls inside the limit; no hysteresis.
// - High flag for samples above high limit; 7FFF disables it.
// - Low flag for samples below low limit; 8000 disables it.
`include "satoc_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module satoc_top (
    input  wire logic                     core_clk,
    input  wire logic                     sys_rst,
    input  wire satoc_pkg::satoc_reg_req_t reg_req,
    output logic [15:0]                   reg_rdata,
    output logic                          reg_rvalid,
    input  wire logic                     modulator_bit,
    input  wire logic                     shunt_converter_a_enable,
    input  wire satoc_pkg::satoc_gain_t    channel_gain_setting,
    input  wire satoc_pkg::satoc_sample_t  raw_sample,
    output satoc_pkg::satoc_sample_t       trimmed_sample,
    input  wire logic                     shared_pin_source_select,
    input  wire logic                     shared_pin_output_format,
    output logic                          high_limit_flag,
    output logic                          low_limit_flag,
    output logic                          overcurrent_fault_output,
    output logic                          shared_pin_o,
    output logic                          shared_pin_oe
);

    localparam int FW = `SATOC_FAST_WIDTH;

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    logic [15:0] otrim_hi_q, otrim_hi_d;
    logic [7:0]  otrim_lo_q, otrim_lo_d;
    logic [15:0] gain_trim_q, gain_trim_d;
    logic [15:0] oc_cfg_q, oc_cfg_d;
    logic [15:0] high_limit_value_q, high_limit_value_d;
    logic [15:0] low_limit_value_q, low_limit_value_d;
    logic [15:0] rdata_d;
    logic        rvalid_d;

    always_comb begin
        otrim_hi_d         = otrim_hi_q;
        otrim_lo_d         = otrim_lo_q;
        gain_trim_d        = gain_trim_q;
        oc_cfg_d           = oc_cfg_q;
        high_limit_value_d = high_limit_value_q;
        low_limit_value_d  = low_limit_value_q;
        if (reg_req.wr) begin
            unique case (reg_req.addr)
                `SATOC_OFS_OTRIM_HI:  otrim_hi_d = reg_req.wdata;
                `SATOC_OFS_OTRIM_LO:  otrim_lo_d =
                    reg_req.wdata[`SATOC_OTRIM_LO_MSB:`SATOC_OTRIM_LO_LSB];
                `SATOC_OFS_GAIN_TRIM: gain_trim_d = reg_req.wdata;
                `SATOC_OFS_OC_CFG:    oc_cfg_d = {reg_req.wdata[15:8], 8'h00};
                `SATOC_OFS_HI_LIMIT:  high_limit_value_d = reg_req.wdata;
                `SATOC_OFS_LO_LIMIT:  low_limit_value_d = reg_req.wdata;
                default: ;
            endcase
        end
        rvalid_d = reg_req.rd;
        rdata_d  = 16'h0000;
        if (reg_req.rd) begin
            unique case (reg_req.addr)
                `SATOC_OFS_OTRIM_HI:  rdata_d = otrim_hi_q;
                `SATOC_OFS_OTRIM_LO:  rdata_d = {otrim_lo_q, 8'h00};
                `SATOC_OFS_GAIN_TRIM: rdata_d = gain_trim_q;
                `SATOC_OFS_OC_CFG:    rdata_d = oc_cfg_q;
                `SATOC_OFS_HI_LIMIT:  rdata_d = high_limit_value_q;
                `SATOC_OFS_LO_LIMIT:  rdata_d = low_limit_value_q;
                default: ;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            otrim_hi_q         <= `SATOC_RST_OTRIM_HI;
            otrim_lo_q         <= `SATOC_RST_OTRIM_LO;
            gain_trim_q        <= `SATOC_RST_GAIN_TRIM;
            oc_cfg_q           <= `SATOC_RST_OC_CFG;
            high_limit_value_q <= `SATOC_RST_HI_LIMIT;
            low_limit_value_q  <= `SATOC_RST_LO_LIMIT;
            reg_rdata          <= 16'h0000;
            reg_rvalid         <= 1'b0;
        end else begin
            otrim_hi_q         <= otrim_hi_d;
            otrim_lo_q         <= otrim_lo_d;
            gain_trim_q        <= gain_trim_d;
            oc_cfg_q           <= oc_cfg_d;
            high_limit_value_q <= high_limit_value_d;
            low_limit_value_q  <= low_limit_value_d;
            reg_rdata          <= rdata_d;
            reg_rvalid         <= rvalid_d;
        end
    end

    // ------------------------------------------------------------------
    // Configuration fields
    // ------------------------------------------------------------------
    logic       overcurrent_enable;
    logic       fault_polarity;
    logic [4:0] deglitch_count_select;
    logic       comp_run;

    assign overcurrent_enable    = oc_cfg_q[`SATOC_BIT_OC_EN];
    assign fault_polarity        = oc_cfg_q[`SATOC_BIT_OC_POL];
    assign deglitch_count_select = oc_cfg_q[`SATOC_DGL_MSB:`SATOC_DGL_LSB];
    // Start and stop commands have no path into the fast filter
    assign comp_run = overcurrent_enable & shunt_converter_a_enable;

    // ------------------------------------------------------------------
    // Offset and gain trim of conversion data
    // ------------------------------------------------------------------
    logic signed [24:0] trim_diff;
    logic signed [17:0] trim_factor;
    logic signed [42:0] trim_prod;
    logic signed [26:0] trim_shift;
    logic [23:0]        trim_sat;
    satoc_pkg::satoc_sample_t trimmed_d;

    always_comb begin
        trim_diff = $signed({raw_sample.data[23], raw_sample.data})
                  - $signed({otrim_hi_q[15], otrim_hi_q, otrim_lo_q});
        trim_factor = $signed(`SATOC_GAIN_UNITY)
                    + $signed({{2{gain_trim_q[15]}}, gain_trim_q});
        trim_prod  = 43'(trim_diff * trim_factor);
        trim_shift = 27'(trim_prod >>> 16);
        if (trim_shift > 27'sh07FFFFF) begin
            trim_sat = 24'h7FFFFF;
        end else if (trim_shift < -27'sh0800000) begin
            trim_sat = 24'h800000;
        end else begin
            trim_sat = trim_shift[23:0];
        end
        trimmed_d.valid = raw_sample.valid;
        trimmed_d.data  = raw_sample.valid ? trim_sat : trimmed_sample.data;
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            trimmed_sample <= '0;
        end else begin
            trimmed_sample <= trimmed_d;
        end
    end

    // ------------------------------------------------------------------
    // Fast filter
    // ------------------------------------------------------------------
    logic                 fast_valid;
    logic signed [FW-1:0] fast_data;

    satoc_sinc3 #(
        .OSR_LOG2 (`SATOC_FAST_OSR_LOG2),
        .WIDTH    (FW)
    ) u_fast_filter (
        .core_clk  (core_clk),
        .sys_rst   (sys_rst),
        .clear     (~comp_run),
        .bit_in    (modulator_bit),
        .out_valid (fast_valid),
        .out_data  (fast_data)
    );

    // ------------------------------------------------------------------
    // Scaling to 16 bits at the channel gain
    // ------------------------------------------------------------------
    logic signed [FW+1:0] scale_ext;
    logic signed [FW+1:0] scale_div;
    logic signed [15:0]   fast_sample;

    always_comb begin
        scale_ext = {{2{fast_data[FW-1]}}, fast_data};
        unique case (channel_gain_setting)
            satoc_pkg::SATOC_GAIN_16: scale_ext = scale_ext <<< 1;
            satoc_pkg::SATOC_GAIN_32: scale_ext = scale_ext <<< 2;
            default: ;
        endcase
        scale_div = scale_ext >>> `SATOC_FAST_SHIFT;
        if (scale_div > (FW+2)'(32767)) begin
            fast_sample = 16'sh7FFF;
        end else if (scale_div < -(FW+2)'(32768)) begin
            fast_sample = 16'sh8000;
        end else begin
            fast_sample = scale_div[15:0];
        end
    end

    // ------------------------------------------------------------------
    // Deglitch count table
    // ------------------------------------------------------------------
    function automatic logic [7:0] satoc_dgl_len(input logic [4:0] code);
        logic [7:0] n;
        n = 8'h00;
        if (code <= 5'h09) begin
            n = 8'({3'b000, code}) + 8'h01;
        end else if (code <= 5'h10) begin
            n = 8'(({3'b000, code} - 8'h04) << 1);
        end else if (code <= 5'h14) begin
            n = 8'(({3'b000, code} - 8'h0A) << 2);
        end else begin
            n = 8'(({3'b000, code} - 8'h0F) << 3);
        end
        return n;
    endfunction : satoc_dgl_len

    // ------------------------------------------------------------------
    // Comparator with deglitch counters
    // ------------------------------------------------------------------
    logic [7:0] dgl_len;
    logic [7:0] hi_cnt_q, hi_cnt_d;
    logic [7:0] lo_cnt_q, lo_cnt_d;
    logic       hi_flag_d, lo_flag_d;
    logic       above_hi, below_lo;

    always_comb begin
        dgl_len   = satoc_dgl_len(deglitch_count_select);
        above_hi  = (high_limit_value_q != `SATOC_RST_HI_LIMIT)
                  && (fast_sample > $signed(high_limit_value_q));
        below_lo  = (low_limit_value_q != `SATOC_RST_LO_LIMIT)
                  && (fast_sample < $signed(low_limit_value_q));
        hi_cnt_d  = hi_cnt_q;
        lo_cnt_d  = lo_cnt_q;
        hi_flag_d = high_limit_flag;
        lo_flag_d = low_limit_flag;
        if (!comp_run) begin
            hi_cnt_d  = 8'h00;
            lo_cnt_d  = 8'h00;
            hi_flag_d = 1'b0;
            lo_flag_d = 1'b0;
        end else if (fast_valid) begin
            if (above_hi) begin
                if (hi_cnt_q < dgl_len) begin
                    hi_cnt_d = hi_cnt_q + 8'h01;
                end
                hi_flag_d = (hi_cnt_q + 8'h01) >= dgl_len;
            end else begin
                hi_cnt_d  = 8'h00;
                hi_flag_d = 1'b0;
            end
            if (below_lo) begin
                if (lo_cnt_q < dgl_len) begin
                    lo_cnt_d = lo_cnt_q + 8'h01;
                end
                lo_flag_d = (lo_cnt_q + 8'h01) >= dgl_len;
            end else begin
                lo_cnt_d  = 8'h00;
                lo_flag_d = 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            hi_cnt_q        <= 8'h00;
            lo_cnt_q        <= 8'h00;
            high_limit_flag <= 1'b0;
            low_limit_flag  <= 1'b0;
        end else begin
            hi_cnt_q        <= hi_cnt_d;
            lo_cnt_q        <= lo_cnt_d;
            high_limit_flag <= hi_flag_d;
            low_limit_flag  <= lo_flag_d;
        end
    end

    // ------------------------------------------------------------------
    // Fault output and shared pin
    // ------------------------------------------------------------------
    logic fault_level;

    always_comb begin
        overcurrent_fault_output = high_limit_flag | low_limit_flag;
        fault_level = fault_polarity ? overcurrent_fault_output
                                     : ~overcurrent_fault_output;
        shared_pin_o  = 1'b0;
        shared_pin_oe = 1'b0;
        if (shared_pin_source_select) begin
            if (shared_pin_output_format) begin
                shared_pin_o  = 1'b0;
                shared_pin_oe = ~fault_level;
            end else begin
                shared_pin_o  = fault_level;
                shared_pin_oe = 1'b1;
            end
        end
    end

endmodule : satoc_top

`default_nettype wire

// *** satoc_top_chk.sv ***
`include "satoc_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module satoc_top_chk (
    input wire logic                      core_clk,
    input wire logic                      sys_rst,
    input wire satoc_pkg::satoc_reg_req_t reg_req,
    input wire logic [15:0]               reg_rdata,
    input wire logic                      reg_rvalid,
    input wire logic                      shunt_converter_a_enable,
    input wire satoc_pkg::satoc_sample_t  raw_sample,
    input wire satoc_pkg::satoc_sample_t  trimmed_sample,
    input wire logic                      shared_pin_source_select,
    input wire logic                      shared_pin_output_format,
    input wire logic                      high_limit_flag,
    input wire logic                      low_limit_flag,
    input wire logic                      overcurrent_fault_output,
    input wire logic                      shared_pin_o,
    input wire logic                      shared_pin_oe
);
    // ------------------------------------------------------------------
    // Shadow of enable and polarity
    // ------------------------------------------------------------------
    logic en_q, en_d, pol_q, pol_d, run, flt;

    always_comb begin
        en_d = en_q;
        pol_d = pol_q;
        if (reg_req.wr && reg_req.addr == `SATOC_OFS_OC_CFG) begin
            en_d = reg_req.wdata[`SATOC_BIT_OC_EN];
            pol_d = reg_req.wdata[`SATOC_BIT_OC_POL];
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            en_q <= 1'b0;
            pol_q <= 1'b0;
        end else begin
            en_q <= en_d;
            pol_q <= pol_d;
        end
    end

    assign run = en_q && shunt_converter_a_enable;
    assign flt = overcurrent_fault_output;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    a_read_answer: assert property (reg_req.rd |=> reg_rvalid)
        else $error("read answer missing");
    a_read_alone: assert property (!reg_req.rd |=> !reg_rvalid)
        else $error("read answer without request");
    a_low_zero: assert property (
        reg_req.rd && reg_req.addr inside {8'h85, 8'h87}
        |=> reg_rdata[7:0] == 8'h00)
        else $error("low byte not zero");
    a_trim_strobe: assert property (
        raw_sample.valid |=> trimmed_sample.valid)
        else $error("trimmed strobe missing");
    a_fault_or: assert property (
        flt == (high_limit_flag || low_limit_flag))
        else $error("fault not the OR of flags");
    a_pin_push: assert property (
        shared_pin_source_select && !shared_pin_output_format
        |-> shared_pin_oe && shared_pin_o == (pol_q ~^ flt))
        else $error("push-pull pin level wrong");
    a_pin_drain: assert property (
        shared_pin_source_select && shared_pin_output_format
        |-> shared_pin_oe == !(pol_q ~^ flt) && !(shared_pin_oe && shared_pin_o))
        else $error("open-drain pin wrong");
    a_pin_idle: assert property (
        !shared_pin_source_select |-> !shared_pin_oe)
        else $error("pin driven while not selected");
    a_flags_off: assert property (
        !run [*2] |-> !high_limit_flag && !low_limit_flag)
        else $error("flag set while comparator off");
    a_flag_hold: assert property (
        $rose(high_limit_flag) ##1 run [*8] |-> high_limit_flag)
        else $error("flag changed between filter outputs");

    c_high: cover property ($rose(high_limit_flag));
    c_low: cover property ($rose(low_limit_flag));
    c_trim: cover property (trimmed_sample.valid);
endmodule : satoc_top_chk

`default_nettype wire

// *** satoc_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none

module satoc_host_model (
    input wire logic                     core_clk,
    output var satoc_pkg::satoc_reg_req_t reg_req,
    input wire logic [15:0]              reg_rdata,
    input wire logic                     reg_rvalid
);
    // ------------------------------------------------------------------
    // Register accesses, driven after the falling edge
    // ------------------------------------------------------------------
    initial reg_req = '0;

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge core_clk);
        reg_req = '{1'b1, 1'b0, a, (a == 8'h87) ? d & 16'hDFFF : d};
        @(negedge core_clk);
        reg_req = '{1'b0, 1'b0, ~a, ~d};
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [15:0] d,
                      output logic v);
        @(negedge core_clk);
        reg_req.rd = 1'b1;
        reg_req.addr = a;
        @(negedge core_clk);
        reg_req.rd = 1'b0;
        reg_req.addr = ~a;
        d = reg_rdata;
        v = reg_rvalid;
    endtask : rd
endmodule : satoc_host_model

`default_nettype wire

// *** satoc_top_tb.sv ***
`timescale 1ns/100ps
`default_nettype none

module satoc_top_tb;
    typedef struct {
        logic [23:0] off;
        logic [15:0] gain;
        logic [23:0] raw;
        logic [23:0] exp;
    } satoc_row_t;

    logic core_clk, sys_rst, mod_bit = 1'b1, chan_en, sel = 1'b1, fmt = 1'b0;
    logic hi, lo, fault, pin_o, pin_oe, rvalid, v;
    logic [15:0] rdata, d;
    satoc_pkg::satoc_reg_req_t req;
    satoc_pkg::satoc_sample_t raw = '0, trim;
    int n_fail = 0, tests_run = 0, cyc = 0, t0, t;
    logic [15:0] rstv [7] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000,
                              16'h7FFF, 16'h8000, 16'h0000};
    logic [4:0] dg_code [6] = '{5'h00, 5'h01, 5'h09, 5'h0A, 5'h10, 5'h1F};
    int dg_cnt [6] = '{1, 2, 10, 12, 24, 128};
    satoc_row_t tr [8] = '{
        '{24'h000000, 16'h0000, 24'h123456, 24'h123456},
        '{24'h000010, 16'h0000, 24'h000100, 24'h0000F0},
        '{24'h000000, 16'h8000, 24'h000100, 24'h000080},
        '{24'h000000, 16'h7FFF, 24'h010000, 24'h017FFF},
        '{24'h000000, 16'h4000, 24'h7FFFFF, 24'h7FFFFF},
        '{24'hFFFFFF, 16'h0000, 24'h800000, 24'h800001},
        '{24'h000001, 16'h0000, 24'h800000, 24'h800000},
        '{24'h000000, 16'hFFFF, 24'h010000, 24'h00FFFF}};

    satoc_top satoc_top_inst (
        .core_clk(core_clk), .sys_rst(sys_rst), .reg_req(req),
        .reg_rdata(rdata), .reg_rvalid(rvalid), .modulator_bit(mod_bit),
        .shunt_converter_a_enable(chan_en),
        .channel_gain_setting(satoc_pkg::SATOC_GAIN_4),
        .raw_sample(raw), .trimmed_sample(trim),
        .shared_pin_source_select(sel), .shared_pin_output_format(fmt),
        .high_limit_flag(hi), .low_limit_flag(lo),
        .overcurrent_fault_output(fault), .shared_pin_o(pin_o),
        .shared_pin_oe(pin_oe));

    satoc_host_model satoc_host_model_inst (
        .core_clk(core_clk), .reg_req(req), .reg_rdata(rdata),
        .reg_rvalid(rvalid));

    // ------------------------------------------------------------------
    // Clock, timeout and reporting
    // ------------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cyc = cyc + 1;
        if (cyc == 60000) begin
            n_fail++;
            final_report();
        end
    end

    task automatic final_report;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : final_report

    task automatic chk_val(input string nm, input logic [23:0] e,
                           input logic [23:0] g);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_val

    task automatic chk_bit(input string nm, input logic e, input logic g);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %b seen %b", nm, e, g);
        end
    endtask : chk_bit

    task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
        satoc_host_model_inst.rd(a, d, v);
        chk_bit("rvalid", 1'b1, v);
        chk_val("rdata", 24'(e), 24'(d));
    endtask : rd_chk

    task automatic wr(input logic [7:0] a, input logic [15:0] x);
        satoc_host_model_inst.wr(a, x);
    endtask : wr

    task automatic wait_flag(input logic lowf, output int n);
        n = 0;
        while (((lowf ? lo : hi) !== 1'b1) && n < 9000) begin
            @(negedge core_clk);
            n++;
        end
    endtask : wait_flag

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        sys_rst = 1'b1;
        chan_en = 1'b1;
        repeat (4) @(negedge core_clk);
        sys_rst = 1'b0;
        chk_bit("pin_o", 1'b1, pin_o);
        for (int i = 0; i < 7; i++) begin
            rd_chk(8'h84 + 8'(i), rstv[i]);
        end
        wr(8'h85, 16'hFFFF);
        rd_chk(8'h85, 16'hFF00);
        wr(8'h87, 16'h5FFF);
        rd_chk(8'h87, 16'h5F00);
        wr(8'h87, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            wr(8'h84, tr[i].off[23:8]);
            wr(8'h85, {tr[i].off[7:0], 8'h00});
            wr(8'h86, tr[i].gain);
            raw = {1'b1, tr[i].raw};
            @(negedge core_clk);
            raw.valid = 1'b0;
            chk_bit("trim_valid", 1'b1, trim.valid);
            chk_val("trim_data", tr[i].exp, trim.data);
        end
        wr(8'h87, 16'h8000);
        repeat (400) @(negedge core_clk);
        chk_bit("high_flag", 1'b0, hi);
        wr(8'h88, 16'h4000);
        for (int i = 0; i < 6; i++) begin
            wr(8'h87, 16'h0000);
            wr(8'h87, {3'b100, dg_code[i], 8'h00});
            wait_flag(1'b0, t);
            if (i == 0) t0 = t;
            chk_bit("high_flag", 1'b1, hi);
            chk_val("deglitch", 24'((dg_cnt[i] - 1) * 64), 24'(t - t0));
        end
        chk_bit("pin_o", 1'b0, pin_o);
        wr(8'h87, 16'hC000);
        chk_bit("pin_o", 1'b1, pin_o);
        fmt = 1'b1;
        @(negedge core_clk);
        chk_bit("pin_oe", 1'b0, pin_oe);
        wr(8'h87, 16'h8000);
        mod_bit = 1'b0;
        repeat (400) @(negedge core_clk);
        chk_bit("high_flag", 1'b0, hi);
        chk_bit("low_flag", 1'b0, lo);
        wr(8'h89, 16'hC000);
        wait_flag(1'b1, t);
        chk_bit("low_flag", 1'b1, lo);
        chk_bit("fault", 1'b1, fault);
        chk_bit("pin_oe", 1'b1, pin_oe);
        sel = 1'b0;
        @(negedge core_clk);
        chk_bit("pin_oe", 1'b0, pin_oe);
        chan_en = 1'b0;
        repeat (2) @(negedge core_clk);
        chk_bit("low_flag", 1'b0, lo);
        final_report();
    end
endmodule : satoc_top_tb

bind satoc_top satoc_top_chk satoc_top_chk_inst (
    .core_clk(core_clk), .sys_rst(sys_rst), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .shunt_converter_a_enable(shunt_converter_a_enable),
    .raw_sample(raw_sample), .trimmed_sample(trimmed_sample),
    .shared_pin_source_select(shared_pin_source_select),
    .shared_pin_output_format(shared_pin_output_format),
    .high_limit_flag(high_limit_flag), .low_limit_flag(low_limit_flag),
    .overcurrent_fault_output(overcurrent_fault_output),
    .shared_pin_o(shared_pin_o), .shared_pin_oe(shared_pin_oe));

`default_nettype wire
